// ==== rtl/reiu_top.sv ====
// How it works
// - Reset pin low halts core, clears registers, flags and sequencer
// - Reset release sets interrupt mask bit
// - Fetch reset vector word, load PC
// - Non-maskable edge chosen by select bit
// - Non-maskable is highest, ignores mask bit
// - Four external inputs, own vectors, edges
// - Enabled pin edge sets its flag
// - Each external input has enable bit
// - Six wake inputs share one vector
// - Wake edge sets flag, common enable
// - Peripheral requests set flags, enable masks
// - Forward only flagged and enabled requests
// - Present highest priority, others stay pending
// - Mask bit blocks all but two
// - Accept at instruction end, stack PC, CONDITION_CODE_REG
// - Set mask after stacking; restore CONDITION_CODE_REG
// - Fetch vector, load PC, start handler
// - Stack four states, vector two, fill eight
// - No interrupt before first instruction completes
// - Word accesses force address bit zero
// - Software masks before changing port mode
// - Flags stay until written with zero
`timescale 1ns/1ps
`default_nettype none
module reiu_top (
  // Clock and bus reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite write
  input  wire logic [31:0]          awaddr,
  input  wire logic                 awvalid,
  output var  logic                 awready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output var  logic                 wready,
  output var  logic [1:0]           bresp,
  output var  logic                 bvalid,
  input  wire logic                 bready,
  // AXI4-Lite read
  input  wire logic [31:0]          araddr,
  input  wire logic                 arvalid,
  output var  logic                 arready,
  output var  logic [31:0]          rdata,
  output var  logic [1:0]           rresp,
  output var  logic                 rvalid,
  input  wire logic                 rready,
  // Pins
  input  wire logic                 chip_clear_pin_n,
  input  wire logic                 nmi_pin,
  input  wire logic [3:0]           ext_int_pins,
  input  wire logic [5:0]           wake_pins,
  // Peripheral and break requests
  input  wire logic                 tmr_req,
  input  wire logic                 dts_req,
  input  wire logic                 abrk_req,
  // CPU core
  input  wire logic                 instr_end,
  input  wire logic [15:0]          core_pc,
  input  wire logic [15:0]          core_sp,
  input  wire logic                 rte_done,
  input  wire logic [7:0]           rte_ccr,
  output var  logic                 core_rst_n,
  output var  logic                 core_hold,
  output var  logic                 pc_load,
  output var  logic [15:0]          pc_value,
  output var  logic                 sp_load,
  output var  logic [15:0]          sp_value,
  output var  logic [7:0]           ccr_out,
  // Stack and vector memory
  output var  reiu_pkg::reiu_mem_t  mem,
  input  wire logic [15:0]          mem_rdata
);
  import reiu_pkg::*;

  logic [11:0] s1_q, s2_q, s3_q;  // Sync chain, edge stage
  logic        rst_all;           // Bus or pin reset
  logic [10:0] rise, fall, hit;   // Edge events
  logic [10:0] esel;              // Chosen edge per pin
  logic [7:0]  esr1_q, ien_q, eflg_q, ccr_q;
  logic [5:0]  esr2_q, port_mode_reg_5_q, wflg_q;
  logic [3:0]  port_mode_reg_1_q;
  logic        nmi_q;             // Non-maskable pending
  logic        first_q;           // First instruction done
  logic [4:0]  awa_q;             // Latched write address
  logic        aw_q, w_q;         // Address/data held
  logic [7:0]  wd_q;
  logic        wr_go;             // Write commits
  logic        wr_ok;             // Write address mapped
  logic [NSRC-1:0] mreq;          // Maskable requests
  logic [4:0]  win;               // Winning vector
  logic        take;              // Accept now
  reiu_st_t    st_q;
  logic [3:0]  cnt_q;
  logic [4:0]  vec_q;
  logic [15:0] vaddr_q, sp_q, ret_q;

  assign rst_all = !aresetn || !s2_q[11];

  // Two-stage sync, third stage for edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Clear-pin bit starts low: chip stays held until pin seen high
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= {chip_clear_pin_n, wake_pins, ext_int_pins, nmi_pin};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Edge detect with per-pin polarity
  assign esel = {esr2_q, esr1_q[3:0], esr1_q[NMI_EDGE_BIT]};
  assign rise = s2_q[10:0] & ~s3_q[10:0];
  assign fall = ~s2_q[10:0] & s3_q[10:0];
  assign hit  = (esel & rise) | (~esel & fall);

  // Write channel handshake
  assign wr_go = aw_q && w_q && !bvalid;
  assign wr_ok = (awa_q[1:0] == 2'h0);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 5'h00;
      wd_q <= 8'h00;
      bvalid <= 1'b0;
      bresp <= RESP_OK;
    end else begin
      if (awvalid && awready) begin
        aw_q <= 1'b1;
        awa_q <= (awaddr[31:5] == 27'h0) ? awaddr[4:0] : 5'h01;
      end
      if (wvalid && wready) begin
        w_q <= 1'b1;
        wd_q <= wstrb[0] ? wdata[7:0] : 8'hff;
      end
      if (wr_go) begin
        // Response after both halves taken
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_ok ? RESP_OK : RESP_ERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end
  assign awready = !aw_q && !bvalid;
  assign wready  = !w_q && !bvalid;

  // Configuration registers
  always_ff @(posedge aclk) begin
    if (rst_all) begin
      esr1_q <= 8'h00;
      esr2_q <= 6'h00;
      port_mode_reg_1_q <= 4'h0;
      port_mode_reg_5_q <= 6'h00;
      ien_q  <= 8'h00;
    end else if (wr_go) begin
      case (awa_q)
        ESR1_OFS: esr1_q <= wd_q;
        ESR2_OFS: esr2_q <= wd_q[5:0];
        PORT_MODE_REG_1_OFS: port_mode_reg_1_q <= wd_q[3:0];
        PORT_MODE_REG_5_OFS: port_mode_reg_5_q <= wd_q[5:0];
        IEN_OFS:  ien_q  <= wd_q;
        default: ;
      endcase
    end
  end

  // Sticky flags; write 0 clears, set wins
  always_ff @(posedge aclk) begin
    if (rst_all) begin
      eflg_q <= 8'h00;
      wflg_q <= 6'h00;
    end else begin
      eflg_q <= ((wr_go && awa_q == EFLG_OFS) ? (eflg_q & wd_q) : eflg_q)
              | {dts_req, tmr_req, 2'h0, hit[4:1] & port_mode_reg_1_q};
      wflg_q <= ((wr_go && awa_q == WFLG_OFS) ? (wflg_q & wd_q[5:0]) : wflg_q)
              | (hit[10:5] & port_mode_reg_5_q);
    end
  end

  // Read channel, one-cycle answer
  assign arready = !rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OK;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= (araddr[31:5] == 27'h0 && araddr[1:0] == 2'h0) ? RESP_OK : RESP_ERR;
      case (araddr[4:0])
        ESR1_OFS: rdata <= {24'h0, esr1_q};
        ESR2_OFS: rdata <= {26'h0, esr2_q};
        PORT_MODE_REG_1_OFS: rdata <= {28'h0, port_mode_reg_1_q};
        PORT_MODE_REG_5_OFS: rdata <= {26'h0, port_mode_reg_5_q};
        EFLG_OFS: rdata <= {24'h0, eflg_q};
        WFLG_OFS: rdata <= {24'h0, WFLG_RSV, wflg_q};
        IEN_OFS:  rdata <= {24'h0, ien_q};
        CCR_OFS:  rdata <= {24'h0, ccr_q};
        default:  rdata <= 32'h0;
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Forward only enabled flags, fixed order
  assign mreq = {eflg_q[TMR_BIT] & ien_q[TMR_BIT], eflg_q[DTS_BIT] & ien_q[DTS_BIT],
                 |wflg_q & ien_q[WAKE_EN_BIT], eflg_q[3:0] & ien_q[3:0]};
  always_comb begin
    win = VEC_MBASE;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (mreq[i]) win = VEC_MBASE + 5'(i);
    end
    if (abrk_req) win = VEC_ABRK;
    if (nmi_q) win = VEC_NMI;
  end
  assign take = st_q == S_RUN && instr_end && first_q &&
                (nmi_q || abrk_req || (!ccr_q[CCR_I_BIT] && |mreq));

  // Non-maskable pending and first instruction
  always_ff @(posedge aclk) begin
    if (rst_all) begin
      nmi_q <= 1'b0;
      first_q <= 1'b0;
    end else begin
      nmi_q <= hit[0] || (nmi_q && !(take && win == VEC_NMI));
      if (st_q == S_RUN && instr_end) first_q <= 1'b1;
    end
  end

  // Condition code register
  always_ff @(posedge aclk) begin
    if (rst_all) begin
      ccr_q <= CCR_RST;
    end else if (st_q == S_RESET) begin
      ccr_q[CCR_I_BIT] <= 1'b1;
    end else if (st_q == S_STK && cnt_q == 4'(STK_ST - 1)) begin
      ccr_q[CCR_I_BIT] <= 1'b1;
    end else if (rte_done) begin
      ccr_q <= rte_ccr;
    end else if (wr_go && awa_q == CCR_OFS) begin
      ccr_q <= wd_q;
    end
  end
  assign ccr_out = ccr_q;

  // Exception sequencer
  always_ff @(posedge aclk) begin
    if (rst_all) begin
      st_q <= S_RESET;
      cnt_q <= 4'h0;
      vec_q <= 5'h00;
      vaddr_q <= RESET_VEC_ADDR;
      sp_q <= 16'h0;
      ret_q <= 16'h0;
      mem <= '0;
      core_rst_n <= 1'b0;
      core_hold <= 1'b1;
      pc_load <= 1'b0;
      pc_value <= 16'h0;
      sp_load <= 1'b0;
      sp_value <= 16'h0;
    end else begin
      pc_load <= 1'b0;
      sp_load <= 1'b0;
      case (st_q)
        S_RESET: begin
          // Reset vector read
          st_q <= S_VEC;
          cnt_q <= 4'h0;
          mem <= '{req: 1'b1, we: 1'b0, addr: RESET_VEC_ADDR, wdata: 16'h0};
        end
        S_RUN: begin
          if (take) begin
            st_q <= S_STK;
            cnt_q <= 4'h0;
            vec_q <= win;
            ret_q <= core_pc;
            sp_q <= {core_sp[15:1], 1'b0} - 16'h0004;
            vaddr_q <= {10'h0, win, 1'b0};
            core_hold <= 1'b1;
            // Return address push
            mem <= '{req: 1'b1, we: 1'b1, addr: {core_sp[15:1], 1'b0} - 16'h0002, wdata: core_pc};
          end
        end
        S_STK: begin
          cnt_q <= cnt_q + 4'h1;
          mem.req <= 1'b0;
          if (cnt_q == 4'h1) begin
            mem <= '{req: 1'b1, we: 1'b1, addr: sp_q, wdata: {ccr_q, ccr_q}};
          end
          if (cnt_q == 4'(STK_ST - 1)) begin
            st_q <= S_VEC;
            cnt_q <= 4'h0;
            sp_load <= 1'b1;
            sp_value <= sp_q;
            mem <= '{req: 1'b1, we: 1'b0, addr: vaddr_q, wdata: 16'h0};
          end
        end
        S_VEC: begin
          cnt_q <= cnt_q + 4'h1;
          mem.req <= 1'b0;
          if (cnt_q == 4'h0) pc_value <= mem_rdata;
          if (cnt_q == 4'(VEC_ST - 1)) begin
            pc_load <= 1'b1;
            cnt_q <= 4'h0;
            st_q <= core_rst_n ? S_FILL : S_RUN;
            core_rst_n <= 1'b1;
            core_hold <= core_rst_n;
          end
        end
        S_FILL: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == 4'(FILL_ST - 1)) begin
            st_q <= S_RUN;
            core_hold <= 1'b0;
          end
        end
        default: st_q <= S_RESET;
      endcase
    end
  end

  a_reset_hold: assert property (@(posedge aclk) rst_all |=> !core_rst_n)
    else $error("core not held in reset");
  a_reset_mask: assert property (@(posedge aclk) disable iff (rst_all)
    st_q == S_RESET |=> ccr_q[CCR_I_BIT] && mem.addr == RESET_VEC_ADDR)
    else $error("reset did not mask");
  a_reset_vec: assert property (@(posedge aclk) disable iff (rst_all)
    st_q == S_RESET |=> ##2 pc_load && st_q == S_RUN)
    else $error("reset vector not loaded");
  a_mask_pend: assert property (@(posedge aclk) disable iff (rst_all)
    st_q == S_RUN && ccr_q[CCR_I_BIT] && !nmi_q && !abrk_req |=> st_q != S_STK)
    else $error("masked request taken");
  a_nmi_take: assert property (@(posedge aclk) disable iff (rst_all)
    st_q == S_RUN && instr_end && first_q && nmi_q |=> st_q == S_STK && vec_q == VEC_NMI)
    else $error("nmi not taken");
  a_first_instr: assert property (@(posedge aclk) disable iff (rst_all)
    st_q == S_RUN && !first_q |=> st_q != S_STK)
    else $error("interrupt before first instruction");
  a_stack_time: assert property (@(posedge aclk) disable iff (rst_all)
    take |=> (st_q == S_STK) [*4] ##1 (st_q == S_VEC) [*2] ##1 pc_load)
    else $error("response timing wrong");
  a_word_align: assert property (@(posedge aclk) disable iff (rst_all)
    mem.req |-> !mem.addr[0])
    else $error("odd word address");
  a_flag_sticky: assert property (@(posedge aclk) disable iff (rst_all)
    !(wr_go && awa_q == EFLG_OFS) |=> (eflg_q & $past(eflg_q)) == $past(eflg_q))
    else $error("flag lost without write");
  a_stack_mask: assert property (@(posedge aclk) disable iff (rst_all)
    st_q == S_STK ##1 st_q == S_VEC |-> ccr_q[CCR_I_BIT])
    else $error("mask not set after stacking");
endmodule
`default_nettype wire

// ==== rtl/reiu_pkg.sv ====
package reiu_pkg;
  // Register byte offsets
  localparam logic [4:0] ESR1_OFS = 5'h00;  // edge_select_reg_1
  localparam logic [4:0] ESR2_OFS = 5'h04;  // edge_select_reg_2
  localparam logic [4:0] PORT_MODE_REG_1_OFS = 5'h08;  // port_mode_reg_1
  localparam logic [4:0] PORT_MODE_REG_5_OFS = 5'h0c;  // port_mode_reg_5
  localparam logic [4:0] EFLG_OFS = 5'h10;  // ext_int_flag_reg
  localparam logic [4:0] WFLG_OFS = 5'h14;  // wake_flag_reg
  localparam logic [4:0] IEN_OFS  = 5'h18;  // int_enable_reg
  localparam logic [4:0] CCR_OFS  = 5'h1c;  // condition_code_reg
  // Field positions
  localparam int NMI_EDGE_BIT = 7;  // Non-maskable edge select
  localparam int WAKE_EN_BIT  = 5;  // wake_common_enable
  localparam int TMR_BIT      = 6;  // Timer flag / enable
  localparam int DTS_BIT      = 7;  // Sleep transfer flag / enable
  localparam int CCR_I_BIT    = 7;  // Interrupt mask bit
  localparam logic [1:0] WFLG_RSV = 2'h3;  // Reserved bits read as 1
  localparam logic [7:0] CCR_RST  = 8'h80;  // Mask set
  // Vectors
  localparam logic [15:0] RESET_VEC_ADDR = 16'h0000;
  localparam logic [4:0] VEC_NMI  = 5'h07;
  localparam logic [4:0] VEC_ABRK = 5'h06;
  localparam logic [4:0] VEC_MBASE = 5'h08;  // First maskable vector
  localparam int NSRC = 7;  // Maskable sources
  // Timing in states
  localparam int STK_ST    = 4;
  localparam int VEC_ST    = 2;
  localparam int IFETCH_ST = 4;
  localparam int INTPR_ST  = 4;
  localparam int FILL_ST   = IFETCH_ST + INTPR_ST;
  localparam int RES_MIN_CYC = 10;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // Stack and vector memory request
  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reiu_mem_t;
  typedef enum logic [2:0] {S_RESET, S_RUN, S_STK, S_VEC, S_FILL} reiu_st_t;
endpackage

// ==== verification/reiu_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module reiu_core_model (
  // Clock and core control
  input  wire logic                aclk,
  input  wire logic                core_rst_n,
  input  wire logic                core_hold,
  input  wire reiu_pkg::reiu_mem_t mem,
  // Core status and memory data
  output var  logic                instr_end,
  output var  logic [15:0]         core_pc,
  output var  logic [15:0]         core_sp,
  output var  logic [15:0]         mem_rdata
);
  import reiu_pkg::*;
  logic [2:0]  step_q;  // Clock within instruction
  logic [15:0] junk_q;  // Idle bus filler
  // Every instruction takes five clocks
  always_ff @(posedge aclk) begin
    if (!core_rst_n || core_hold) step_q <= 3'h0;
    else step_q <= (step_q == 3'h4) ? 3'h0 : step_q + 3'h1;
  end
  // Filler changes every clock once core is out of reset, held at zero in reset
  always_ff @(posedge aclk) junk_q <= core_rst_n ? junk_q + 16'h3c5b : 16'h0;
  assign instr_end = core_rst_n && !core_hold && step_q == 3'h4;
  assign core_pc   = 16'h1234;  // Return address
  assign core_sp   = 16'h0ff1;  // Odd on purpose
  // Reads answer at once
  assign mem_rdata = (mem.req && !mem.we) ? (16'h4000 | mem.addr) : junk_q;
endmodule
`default_nettype wire

// ==== verification/test_reset_and_interrupt_exception_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_reset_and_interrupt_exception_unit;
  import reiu_pkg::*;
  // Design wires
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, nmi_pin;
  logic        chip_clear_pin_n, tmr_req, dts_req, abrk_req, instr_end;
  logic        rte_done, core_rst_n, core_hold, pc_load, sp_load, edge_sel;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb, ext_int_pins;
  logic [1:0]  bresp, rresp;
  logic [5:0]  wake_pins;
  logic [15:0] core_pc, core_sp, pc_value, sp_value, mem_rdata;
  logic [7:0]  rte_ccr, ccr_out, esr1;
  reiu_mem_t   mem;
  // Expected results, oldest first
  logic [33:0] qr[$];
  logic [31:0] qm[$];
  logic [15:0] qp[$];
  logic [1:0]  qb[$];
  int          n_errors, comparisons, seed;

  reiu_top DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .chip_clear_pin_n, .nmi_pin, .ext_int_pins,
    .wake_pins, .tmr_req, .dts_req, .abrk_req, .instr_end, .core_pc, .core_sp,
    .rte_done, .rte_ccr, .core_rst_n, .core_hold, .pc_load, .pc_value, .sp_load,
    .sp_value, .ccr_out, .mem, .mem_rdata);
  reiu_core_model core (.aclk, .core_rst_n, .core_hold, .mem, .instr_end,
    .core_pc, .core_sp, .mem_rdata);

  // 25 MHz clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // Compare and count
  task automatic chk(input logic [47:0] s, input logic [47:0] x);
    comparisons++;
    if (s !== x) begin
      n_errors++;
      $display("FAIL t=%0t seen %h expected %h", $time, s, x);
    end
  endtask

  // Counts, verdict, end of run
  task automatic give_verdict;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Write one register word
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] x,
                    input logic [2:0] h = 3'h0);
    bit fa = 1'b0;
    bit fw = 1'b0;
    qb.push_back(x);
    @(posedge aclk);
    awaddr <= {24'h0, h, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) fa = 1'b1;
      if (wvalid && wready) fw = 1'b1;
      awvalid <= !fa;
      wvalid <= !fw;
    end while (!(fa && fw));
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
  endtask

  // Read one register word
  task automatic rd(input logic [4:0] a, input logic [33:0] x);
    qr.push_back(x);
    @(posedge aclk);
    araddr <= {27'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
  endtask

  // Stack words at rounded-down odd stack pointer, then handler address
  task automatic expect_int(input logic [4:0] v, input logic [7:0] c);
    qm.push_back({16'h0fee, 16'h1234});
    qm.push_back({16'h0fec, c, c});
    qp.push_back(16'h4000 | {10'h0, v, 1'b0});
  endtask

  // Wait for handler start, optionally clear flags, then return
  task automatic finish_int(input logic [7:0] rc, input bit clr);
    for (int i = 0; i < 100 && (qp.size() > 0 || core_hold); i++) @(posedge aclk);
    rd(CCR_OFS, {RESP_OK, 32'h80});
    if (clr) begin
      wr(EFLG_OFS, 32'h0, RESP_OK);
      wr(WFLG_OFS, 32'h0, RESP_OK);
      rd(EFLG_OFS, {RESP_OK, 32'h0});
    end
    @(posedge aclk);
    rte_done <= 1'b1;
    rte_ccr <= rc;
    @(posedge aclk);
    rte_done <= 1'b0;
    rd(CCR_OFS, {RESP_OK, 24'h0, rc});
  endtask

  // Result watcher
  always @(posedge aclk) begin
    if (rvalid && rready) chk({rresp, rdata}, qr.size() ? qr.pop_front() : 'x);
    if (bvalid && bready) chk(bresp, qb.size() ? qb.pop_front() : 'x);
    if (mem.req && mem.we) chk({mem.addr, mem.wdata}, qm.size() ? qm.pop_front() : 'x);
    if (pc_load) chk(pc_value, qp.size() ? qp.pop_front() : 'x);
    if (pc_load) chk(ccr_out[CCR_I_BIT], 1'b1);
    if (sp_load) chk(sp_value, 16'h0fec);
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    give_verdict();
  end

  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, nmi_pin} = '0;
    {chip_clear_pin_n, tmr_req, dts_req, abrk_req, rte_done} = '0;
    {awaddr, wdata, araddr, ext_int_pins, wake_pins, rte_ccr} = '0;
    wstrb = 4'hf;
    esr1 = 8'h81;
    seed = 29797;
    n_errors = 0;
    comparisons = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    qp.push_back(16'h4000);
    repeat (9) @(posedge aclk);
    chip_clear_pin_n <= 1'b1;  // Held low twelve clocks
    for (int i = 0; i < 40 && core_rst_n !== 1'b1; i++) @(posedge aclk);
    rd(CCR_OFS, {RESP_OK, 32'h80});
    rd(WFLG_OFS, {RESP_OK, 32'hc0});
    wr(5'h00, 32'h0, RESP_ERR, 3'h1);
    rd(5'h02, {RESP_ERR, 32'h0});
    wr(ESR1_OFS, 32'h81, RESP_OK);
    wr(PORT_MODE_REG_1_OFS, 32'h0f, RESP_OK);
    wr(PORT_MODE_REG_5_OFS, 32'h01, RESP_OK);
    wr(IEN_OFS, 32'h6f, RESP_OK);
    rd(IEN_OFS, {RESP_OK, 32'h6f});
    // Non-maskable edge taken while masked
    expect_int(VEC_NMI, 8'h80);
    nmi_pin <= 1'b1;
    finish_int(8'h80, 1'b1);
    // External input 0 waits for the mask bit
    ext_int_pins[0] <= 1'b1;
    repeat (8) @(posedge aclk);
    rd(EFLG_OFS, {RESP_OK, 32'h01});
    expect_int(VEC_MBASE, 8'h00);
    wr(CCR_OFS, 32'h0, RESP_OK);
    finish_int(8'h00, 1'b1);
    // Inputs 1 to 3 and wake 0 with random edge choice
    for (int k = 1; k < 5; k++) begin
      edge_sel = 1'($random(seed));
      esr1[k] = edge_sel;
      if (k < 4) wr(ESR1_OFS, {24'h0, esr1}, RESP_OK);
      else wr(ESR2_OFS, {31'h0, edge_sel}, RESP_OK);
      expect_int(VEC_MBASE + 5'(k), 8'h00);
      if (k < 4) ext_int_pins[k] <= 1'b1;
      else wake_pins[0] <= 1'b1;
      repeat (8) @(posedge aclk);
      if (k < 4) ext_int_pins[k] <= 1'b0;
      else wake_pins[0] <= 1'b0;
      finish_int(8'h00, 1'b1);
    end
    // Timer pending behind a falling non-maskable edge
    wr(CCR_OFS, 32'h80, RESP_OK);
    esr1[7] = 1'b0;
    wr(ESR1_OFS, {24'h0, esr1}, RESP_OK);
    @(posedge aclk);
    tmr_req <= 1'b1;
    @(posedge aclk);
    tmr_req <= 1'b0;
    expect_int(VEC_NMI, 8'h80);
    nmi_pin <= 1'b0;
    finish_int(8'h80, 1'b0);
    expect_int(VEC_MBASE + 5'h6, 8'h00);
    wr(CCR_OFS, 32'h0, RESP_OK);
    finish_int(8'h00, 1'b1);
    // Sleep transfer flag set but not enabled
    @(posedge aclk);
    dts_req <= 1'b1;
    @(posedge aclk);
    dts_req <= 1'b0;
    repeat (8) @(posedge aclk);
    rd(EFLG_OFS, {RESP_OK, 32'h80});
    // Address break taken while masked
    wr(CCR_OFS, 32'h80, RESP_OK);
    expect_int(VEC_ABRK, 8'h80);
    abrk_req <= 1'b1;
    for (int i = 0; i < 40 && !core_hold; i++) @(posedge aclk);
    abrk_req <= 1'b0;
    finish_int(8'h80, 1'b0);
    // Clear pin low ten clocks mid-run
    qp.push_back(16'h4000);
    chip_clear_pin_n <= 1'b0;
    repeat (10) @(posedge aclk);
    chip_clear_pin_n <= 1'b1;
    for (int i = 0; i < 40 && (qp.size() > 0 || core_rst_n !== 1'b1); i++) @(posedge aclk);
    rd(IEN_OFS, {RESP_OK, 32'h0});
    rd(EFLG_OFS, {RESP_OK, 32'h0});
    rd(CCR_OFS, {RESP_OK, 32'h80});
    repeat (20) @(posedge aclk);
    chk(qp.size() + qm.size() + qr.size() + qb.size(), 48'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
